// [spm_defs.svh]
// offsets, field positions, reset values and counts of the protection monitor
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH

// register byte offsets on the slave port
`define CTRL_OFS       8'h00
`define SVC_OFS        8'h04
`define RSTAT_OFS      8'h08
`define ISTAT_OFS      8'h0C
`define IMASK_OFS      8'h10

// control reset: watchdog on, prescale bit loaded from the inverted mode pin
`define CTRL_RST       8'h80

// service keys, first and second
`define SVC_ARM        8'h55
`define SVC_FIRE       8'hAA

// reset status bit positions
`define RSTAT_WD_BIT   5
`define RSTAT_HALT_BIT 4
`define RSTAT_TEST_BIT 0

// watchdog: 512-tick prescaler, base divide of 2^9 ticks
`define WD_PRE_MAX     9'h1FF
`define WD_BASE_CNT    16'h0200

// bus monitor base timeout of 64 system clocks
`define BM_BASE        7'h40

`endif

// [spm_pkg.sv]
// types and decode functions of the protection monitor
`include "spm_defs.svh"

package spm_pkg;

    typedef struct packed {
        logic       wd_en;
        logic       wd_pre;
        logic [1:0] wd_time;
        logic       halt_en;
        logic       bus_en;
        logic [1:0] bus_time;
    } ctrl_type;

    // sticky event bits: bus error, halt, watchdog
    typedef struct packed {
        logic bus_err;
        logic halt;
        logic wd;
    } event_type;

    typedef enum logic [2:0] {
        BM_IDLE  = 3'b001,
        BM_COUNT = 3'b010,
        BM_DONE  = 3'b100
    } bm_state_type;

    // last tick index before timeout: 2^(9+2t) ticks
    function automatic logic [14:0] wd_limit(input logic [1:0] t);
        logic [15:0] full;
        full = (`WD_BASE_CNT << {t, 1'b0}) - 16'h0001;
        return full[14:0];
    endfunction : wd_limit

    // bus timeout in system clocks: 64 >> field
    function automatic logic [6:0] bm_limit(input logic [1:0] t);
        return `BM_BASE >> t;
    endfunction : bm_limit

endpackage : spm_pkg

// [spm_wd_counter.sv]
// software watchdog prescaler and timeout counter
`timescale 1ns/1ns
`default_nettype none
`include "spm_defs.svh"

module spm_wd_counter
    import spm_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              srst_i,
    input  wire spm_pkg::ctrl_type cfg_i,
    input  wire logic              xtal_tick_i,
    input  wire logic              kick_i,
    output logic                   expire_o
);
    import spm_pkg::*;

    logic [8:0]  pre_q;
    logic [14:0] cnt_q;
    logic        tick;
    logic        last;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    // tick on every rising crystal edge, or only on the 512th one when wd_pre is set
    assign tick = xtal_tick_i &
                  (!cfg_i.wd_pre || pre_q == `WD_PRE_MAX); // see (RULE2)
    assign last = cnt_q == wd_limit(cfg_i.wd_time); // see (RULE4)

    always_ff @(posedge ref_clk_i) begin
        if (srst_i || !cfg_i.wd_en || kick_i) begin // see (RULE1)
            pre_q <= '0;
        end else if (xtal_tick_i) begin
            pre_q <= pre_q + 9'h001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i || !cfg_i.wd_en || kick_i || expire_o) begin // see (RULE13)
            cnt_q <= '0;
        end else if (tick) begin
            cnt_q <= cnt_q + 15'h0001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            expire_o <= 1'b0;
        end else begin
            expire_o <= cfg_i.wd_en && !kick_i && tick && last; // see (RULE5)
        end
    end

    wd_idle_a: assert property ( // see (RULE1)
        !cfg_i.wd_en |=> !expire_o)
        else $error("watchdog expired while disabled");

    pre_gate_a: assert property ( // see (RULE2)
        cfg_i.wd_pre && pre_q != `WD_PRE_MAX |-> !tick)
        else $error("prescaled tick before 512 crystal edges");

    wd_expire_a: assert property ( // see (RULE5)
        cfg_i.wd_en && !kick_i && tick && last |=> expire_o ##1 !expire_o)
        else $error("watchdog missed its divide count");

    kick_clear_a: assert property ( // see (RULE13)
        kick_i |=> cnt_q == '0 && !expire_o)
        else $error("service did not restart the watchdog");

endmodule : spm_wd_counter

`default_nettype wire

// [spm_protection_monitor.sv]
// system protection monitor: watchdog, halt and bus monitors, registers
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "spm_defs.svh"

// What this block does
// (RULE1) watchdog runs only when enable bit set
// (RULE2) prescale bit divides watchdog clock by 512
// (RULE3) prescale bit resets to inverted clock mode pin
// (RULE4) timing field picks watchdog divide ratio
// (RULE5) timeout is divide count of crystal ticks
// (RULE6) halt monitor acts only when enabled
// (RULE7) external bus cycles monitored only when enabled
// (RULE8) bus timeout 64, 32, 16 or 8 clocks
// (RULE9) test reset flag marks test-caused reset
// (RULE10) watchdog flag marks watchdog-caused reset
// (RULE11) halt flag marks halt-caused reset
// (RULE12) software writes 55 then AA to service
// (RULE13) service restarts count, expiry resets system
// (RULE14) unterminated monitored cycle ends with bus error
module spm_protection_monitor
    import spm_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    input  wire logic        por_i,
    input  wire logic        clock_mode_pin_i,
    input  wire logic        crystal_input_i,
    input  wire logic        test_reset_i,
    input  wire logic        halted_i,
    input  wire logic        ext_cycle_i,
    input  wire logic        cycle_ack_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             system_reset_o,
    output logic             bus_error_o,
    output logic             irq_o
);
    import spm_pkg::*;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    // pin synchronisers, left out of reset so they sample throughout
    logic cm_s1_q;
    logic cm_s2_q;
    logic xt_s1_q;
    logic xt_s2_q;
    logic xt_s3_q;

    ctrl_type     ctrl_q;
    event_type    istat_q;
    event_type    imask_q;
    event_type    ev;
    logic [7:0]   rstat_q;
    logic [2:0]   cause_q;
    logic         armed_q;
    logic         halt_prev_q;
    logic         rst_seen_q;
    logic [6:0]   bm_cnt_q;
    bm_state_type bm_state_q;

    logic xtal_tick;
    logic wd_expire;
    logic halt_ev;
    logic bm_fire;
    logic req;
    logic done;
    logic wr_done;
    logic kick;

    always_ff @(posedge ref_clk_i) begin
        cm_s1_q <= clock_mode_pin_i;
        cm_s2_q <= cm_s1_q;
        xt_s1_q <= crystal_input_i;
        xt_s2_q <= xt_s1_q;
        xt_s3_q <= xt_s2_q;
    end

    assign xtal_tick = xt_s2_q && !xt_s3_q;

    // --- slave port: one wait cycle per access
    assign req     = avs_read_i || avs_write_i;
    assign done    = req && !avs_waitrequest_o;
    assign wr_done = done && avs_write_i;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !(req && avs_waitrequest_o);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && avs_waitrequest_o) begin
            unique case (avs_address_i)
                `CTRL_OFS:  avs_readdata_o <= {24'h00_0000, ctrl_q};
                `RSTAT_OFS: avs_readdata_o <= {24'h00_0000, rstat_q};
                `ISTAT_OFS: avs_readdata_o <= {29'h0000_0000, istat_q};
                `IMASK_OFS: avs_readdata_o <= {29'h0000_0000, imask_q};
                default:    avs_readdata_o <= '0;
            endcase
        end
    end

    // --- control register
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ctrl_q        <= `CTRL_RST;
            ctrl_q.wd_pre <= !cm_s2_q; // see (RULE3)
        end else if (wr_done && avs_address_i == `CTRL_OFS) begin
            ctrl_q <= avs_writedata_i[7:0];
        end
    end

    // --- service sequence; other values leave the arm state alone
    assign kick = wr_done && avs_address_i == `SVC_OFS &&
                  avs_writedata_i[7:0] == `SVC_FIRE && armed_q; // see (RULE12)

    always_ff @(posedge ref_clk_i) begin
        if (srst_i || kick) begin
            armed_q <= 1'b0;
        end else if (wr_done && avs_address_i == `SVC_OFS &&
                     avs_writedata_i[7:0] == `SVC_ARM) begin
            armed_q <= 1'b1; // see (RULE12)
        end
    end

    spm_wd_counter u_wd (
        .ref_clk_i   (ref_clk_i),
        .srst_i      (srst_i),
        .cfg_i       (ctrl_q),
        .xtal_tick_i (xtal_tick),
        .kick_i      (kick),
        .expire_o    (wd_expire)
    );

    // --- halt monitor, one event per entry into halt
    assign halt_ev = ctrl_q.halt_en && halted_i && !halt_prev_q; // see (RULE6)

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            halt_prev_q <= 1'b0;
        end else begin
            halt_prev_q <= halted_i;
        end
    end

    // --- bus monitor
    assign bm_fire = bm_state_q == BM_COUNT && ext_cycle_i &&
                     !cycle_ack_i && ctrl_q.bus_en &&
                     bm_cnt_q == bm_limit(ctrl_q.bus_time); // see (RULE8)

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            bm_state_q <= BM_IDLE;
            bm_cnt_q   <= '0;
        end else begin
            unique case (bm_state_q)
                BM_IDLE: begin
                    bm_cnt_q <= 7'h01;
                    if (ctrl_q.bus_en && ext_cycle_i && !cycle_ack_i) begin
                        bm_state_q <= BM_COUNT; // see (RULE7)
                    end
                end
                BM_COUNT: begin
                    // clearing the enable mid-cycle abandons the watch
                    if (!ext_cycle_i || cycle_ack_i || !ctrl_q.bus_en) begin
                        bm_state_q <= BM_IDLE;
                    end else if (bm_fire) begin
                        bm_state_q <= BM_DONE; // see (RULE14)
                    end else begin
                        bm_cnt_q <= bm_cnt_q + 7'h01;
                    end
                end
                BM_DONE: begin
                    if (!ext_cycle_i) begin
                        bm_state_q <= BM_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            bus_error_o <= 1'b0;
        end else begin
            bus_error_o <= bm_fire; // see (RULE14)
        end
    end

    // --- system reset request
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            system_reset_o <= 1'b0;
        end else begin
            system_reset_o <= wd_expire || halt_ev || test_reset_i; // see (RULE13)
        end
    end

    // marks the first cycle out of reset, when the old cause is dropped
    always_ff @(posedge ref_clk_i) begin
        rst_seen_q <= srst_i;
    end

    // cause held through srst_i so every reset edge loads the same status
    always_ff @(posedge ref_clk_i) begin
        if (por_i) begin
            cause_q <= '0;
        end else if (!srst_i && (rst_seen_q || wd_expire || halt_ev ||
                                 test_reset_i)) begin
            cause_q <= {wd_expire, halt_ev, test_reset_i};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (por_i) begin
            rstat_q <= '0;
        end else if (srst_i) begin
            rstat_q                  <= '0;
            rstat_q[`RSTAT_WD_BIT]   <= cause_q[2]; // see (RULE10)
            rstat_q[`RSTAT_HALT_BIT] <= cause_q[1]; // see (RULE11)
            rstat_q[`RSTAT_TEST_BIT] <= cause_q[0]; // see (RULE9)
        end
    end

    // --- interrupt status, set wins over a write-one clear
    assign ev = '{bus_err: bm_fire, halt: halt_ev, wd: wd_expire};

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            istat_q <= '0;
        end else if (wr_done && avs_address_i == `ISTAT_OFS) begin
            istat_q <= (istat_q & ~avs_writedata_i[2:0]) | ev;
        end else begin
            istat_q <= istat_q | ev;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            imask_q <= '0;
        end else if (wr_done && avs_address_i == `IMASK_OFS) begin
            imask_q <= avs_writedata_i[2:0];
        end
    end

    // one cycle behind the status so the output stays a flop
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(istat_q & imask_q);
        end
    end

    // --- checks
    swp_reset_a: assert property ( // see (RULE3)
        @(posedge ref_clk_i) srst_i |=> ctrl_q.wd_pre == !$past(cm_s2_q))
        else $error("prescale bit not inverse of mode pin");

    halt_reset_a: assert property ( // see (RULE6)
        halt_ev |=> system_reset_o && cause_q[1])
        else $error("halt did not raise a system reset");

    halt_off_a: assert property ( // see (RULE6)
        !ctrl_q.halt_en && !wd_expire && !test_reset_i |=> !system_reset_o)
        else $error("reset raised with halt monitor disabled");

    bus_gate_a: assert property ( // see (RULE7)
        bus_error_o |-> $past(ctrl_q.bus_en) && $past(ext_cycle_i))
        else $error("bus error on an unmonitored cycle");

    bus_time_a: assert property ( // see (RULE8)
        bm_state_q == BM_IDLE && ctrl_q.bus_en && ctrl_q.bus_time == 2'b11
        && ext_cycle_i && !cycle_ack_i ##1
        (ext_cycle_i && !cycle_ack_i && $stable(ctrl_q)) [*8]
        |=> bus_error_o)
        else $error("bus timeout of 8 clocks missed");

    bus_err_a: assert property ( // see (RULE14)
        bus_error_o |=> !bus_error_o)
        else $error("bus error longer than one cycle");

    rst_cause_a: assert property ( // see (RULE10)
        @(posedge ref_clk_i) disable iff (por_i)
        srst_i ##0 $past(cause_q[2]) |=> rstat_q[`RSTAT_WD_BIT])
        else $error("watchdog cause not recorded");

    wd_reset_a: assert property ( // see (RULE13)
        wd_expire |=> system_reset_o && cause_q[2])
        else $error("watchdog expiry gave no reset");

    test_reset_a: assert property ( // see (RULE9)
        test_reset_i |=> system_reset_o && cause_q[0])
        else $error("test request gave no reset");

    rst_test_a: assert property ( // see (RULE9)
        @(posedge ref_clk_i) disable iff (por_i)
        srst_i ##0 $past(cause_q[0]) |=> rstat_q[`RSTAT_TEST_BIT])
        else $error("test cause not recorded");

    rst_halt_a: assert property ( // see (RULE11)
        @(posedge ref_clk_i) disable iff (por_i)
        srst_i ##0 $past(cause_q[1]) |=> rstat_q[`RSTAT_HALT_BIT])
        else $error("halt cause not recorded");

    arm_key_a: assert property ( // see (RULE12)
        wr_done && avs_address_i == `SVC_OFS &&
        avs_writedata_i[7:0] == `SVC_ARM |=> armed_q)
        else $error("first service key did not arm");

    bus_idle_a: assert property ( // see (RULE7)
        !ctrl_q.bus_en |=> !bus_error_o)
        else $error("bus error with bus monitor disabled");

    bus_abort_a: assert property ( // see (RULE14)
        bm_state_q == BM_COUNT && (cycle_ack_i || !ext_cycle_i)
        |=> bm_state_q == BM_IDLE && !bus_error_o)
        else $error("terminated cycle not released");

    bus_flag_a: assert property ( // see (RULE14)
        bm_fire |=> istat_q.bus_err)
        else $error("bus error not flagged in status");

    wd_flag_a: assert property ( // see (RULE13)
        wd_expire |=> istat_q.wd)
        else $error("watchdog expiry not flagged in status");

    ctrl_write_a: assert property ( // see (RULE1)
        wr_done && avs_address_i == `CTRL_OFS
        |=> ctrl_q == $past(avs_writedata_i[7:0]))
        else $error("control write did not land");

    irq_level_a: assert property (
        |(istat_q & imask_q) |=> irq_o)
        else $error("unmasked status gave no interrupt");

endmodule : spm_protection_monitor

`default_nettype wire

// [tb_protection_monitor.sv]
// self-checking bench of the protection monitor through its register port
`timescale 1ns/1ns
`default_nettype none
`include "spm_defs.svh"

`define CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end

module testbench;
    logic        ref_clk_i;
    logic        init_rst;
    logic        por_i;
    logic        pin;
    logic        xtal;
    logic        test_rst;
    logic        halted;
    logic        ext_cyc;
    logic        ack;
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        waitreq;
    logic        sys_rst;
    logic        bus_err;
    logic        irq;
    logic [1:0]  loop_q;
    wire         srst = init_rst | (loop_q != 2'd0);
    int          errors;
    int          check_count;
    int          cycles;
    int          rst_cnt;
    int          n;
    int          base;

    spm_protection_monitor spm_protection_monitor_i (
        .ref_clk_i(ref_clk_i), .srst_i(srst), .por_i(por_i),
        .clock_mode_pin_i(pin), .crystal_input_i(xtal),
        .test_reset_i(test_rst), .halted_i(halted),
        .ext_cycle_i(ext_cyc), .cycle_ack_i(ack),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .system_reset_o(sys_rst),
        .bus_error_o(bus_err), .irq_o(irq));

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // system reset request loops back as a 3-cycle reset
    always @(posedge ref_clk_i) begin
        cycles++;
        if (sys_rst === 1'b1) begin
            rst_cnt++;
            loop_q <= 2'd3;
        end else if (loop_q != 2'd0) begin
            loop_q <= loop_q - 2'd1;
        end
        if (cycles == 40000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk_i);
        addr  <= a;
        wdata <= d;
        rd    <= ~w;
        wr    <= w;
        // no local limit: the cycle ceiling ends a hung access
        do begin
            @(posedge ref_clk_i);
        end while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        `CHK(q, e)
    endtask : rd_chk

    task automatic service();
        wr_reg(`SVC_OFS, 32'h0000_0055);
        wr_reg(`SVC_OFS, 32'h0000_00AA);
    endtask : service

    // crystal held 2 cycles high and 2 low per tick
    task automatic ticks(input int t);
        repeat (t) begin
            @(posedge ref_clk_i);
            xtal <= 1'b1;
            repeat (2) @(posedge ref_clk_i);
            xtal <= 1'b0;
            @(posedge ref_clk_i);
        end
    endtask : ticks

    task automatic idle(input int c);
        repeat (c) @(posedge ref_clk_i);
    endtask : idle

    // counts edges from launch until the bus error pulse, 100 if none
    task automatic bm_run(input logic a);
        @(posedge ref_clk_i);
        ext_cyc <= 1'b1;
        ack     <= a;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (bus_err !== 1'b1 && n < 100);
        ext_cyc <= 1'b0;
        ack     <= 1'b0;
        idle(3);
    endtask : bm_run

    initial begin
        {por_i, init_rst, pin} = 3'b111;
        {xtal, test_rst, halted, ext_cyc, ack, rd, wr} = 7'b000_0000;
        addr   = 8'h00;
        wdata  = 32'h0000_0000;
        loop_q = 2'd0;
        idle(3);
        init_rst <= 1'b0;
        por_i    <= 1'b0;
        idle(2);
        rd_chk(`CTRL_OFS, 32'h0000_0080);
        rd_chk(`RSTAT_OFS, 32'h0000_0000);
        rd_chk(`ISTAT_OFS, 32'h0000_0000);
        wr_reg(8'h40, 32'h0000_00FF);
        rd_chk(8'h40, 32'h0000_0000);
        rd_chk(`CTRL_OFS, 32'h0000_0080);
        // watchdog off: no expiry however long
        wr_reg(`CTRL_OFS, 32'h0000_0000);
        ticks(600);
        `CHK(rst_cnt, 0)
        wr_reg(`CTRL_OFS, 32'h0000_0080);
        service();
        ticks(300);
        // keys in the wrong order must not restart the count
        wr_reg(`SVC_OFS, 32'h0000_00AA);
        wr_reg(`SVC_OFS, 32'h0000_0055);
        ticks(205);
        `CHK(rst_cnt, 0)
        ticks(10);
        `CHK(rst_cnt, 1)
        idle(8);
        rd_chk(`RSTAT_OFS, 32'h0000_0020);
        ticks(505);
        service();
        ticks(505);
        `CHK(rst_cnt, 1)
        ticks(10);
        `CHK(rst_cnt, 2)
        idle(8);
        wr_reg(`CTRL_OFS, 32'h0000_0090);
        service();
        ticks(2040);
        `CHK(rst_cnt, 2)
        ticks(16);
        `CHK(rst_cnt, 3)
        idle(8);
        // mode pin low: prescale on at reset
        pin      <= 1'b0;
        init_rst <= 1'b1;
        idle(4);
        init_rst <= 1'b0;
        idle(2);
        rd_chk(`CTRL_OFS, 32'h0000_00C0);
        ticks(600);
        `CHK(rst_cnt, 3)
        wr_reg(`CTRL_OFS, 32'h0000_0080);
        pin <= 1'b1;
        service();
        ticks(520);
        `CHK(rst_cnt, 4)
        idle(8);
        halted <= 1'b1;
        idle(10);
        `CHK(rst_cnt, 4)
        halted <= 1'b0;
        wr_reg(`CTRL_OFS, 32'h0000_0088);
        halted <= 1'b1;
        idle(10);
        halted <= 1'b0;
        `CHK(rst_cnt, 5)
        rd_chk(`RSTAT_OFS, 32'h0000_0010);
        test_rst <= 1'b1;
        @(posedge ref_clk_i);
        test_rst <= 1'b0;
        idle(10);
        `CHK(rst_cnt, 6)
        rd_chk(`RSTAT_OFS, 32'h0000_0001);
        for (int t = 0; t < 4; t++) begin
            base = 64 >> t;
            wr_reg(`CTRL_OFS, 32'h0000_0084 | t);
            bm_run(1'b0);
            // error launched N edges after the cycle is first seen,
            // read back one edge later
            `CHK(n, base + 2)
            rd_chk(`ISTAT_OFS, 32'h0000_0004);
            `CHK(irq, 1'b0)
            wr_reg(`IMASK_OFS, 32'h0000_0004);
            idle(2);
            `CHK(irq, 1'b1)
            wr_reg(`ISTAT_OFS, 32'h0000_0004);
            idle(2);
            `CHK(irq, 1'b0)
            wr_reg(`IMASK_OFS, 32'h0000_0000);
        end
        wr_reg(`CTRL_OFS, 32'h0000_0083);
        bm_run(1'b0);
        `CHK(n, 100)
        wr_reg(`CTRL_OFS, 32'h0000_0087);
        bm_run(1'b1);
        `CHK(n, 100)
        rd_chk(`ISTAT_OFS, 32'h0000_0000);
        final_report();
    end
endmodule : testbench

`default_nettype wire
